// *** include/wrs_pkg.sv ***
// constants and types shared by the wormhole routing switch core
// How it works
// [RULE1] per-entry option strips logical address 32-255
// [RULE2] at most one leading character removed here
// [RULE3] look up, then strip, then forward packet
// [RULE4] allocate output, connect when it accepts packets
// [RULE5] connected input passes each character straight through
// [RULE6] output sends no new packet before end
// [RULE7] stalls propagate both ways through the connection
// [RULE8] busy output holds new packet at input
// [RULE9] contending inputs chosen fairly, none excluded
// [RULE10] winner sends one packet, then output released
// [RULE11] adaptive entry may use any free listed port
// [RULE12] all busy: arbitrate per port as freed
// [RULE13] multicast entry sends packet through whole set
// [RULE14] multicast starts only when all set ready
// [RULE15] multicast character waits until all ports ready
// [RULE16] disabled ports dropped from multicast set
// [RULE17] reset: entries invalid, adaptive and multicast off
// [RULE18] one shared configurable stuck-packet time-out
// [RULE19] stuck: started, unfinished, idle past time-out
// [RULE20] stuck: discard rest, send error end, record
// [RULE21] time-out can be disabled entirely
// [RULE22] table and time-out set only via config
// [RULE23] address 0 config port, 1-31 physical port; here address 0 routes to link port 0 and only addresses below NP are accepted
// [RULE24] path address character always removed after use
// [RULE25] bad port or invalid entry: discard, flag
// [RULE26] round-robin pointer per output past last winner
// [RULE27] per-port cycle counter reloads on data passed
package wrs_pkg;

    // =====================================================
    // characters
    localparam int             CH_W      = 9;
    localparam int             CH_CTL    = 8;
    localparam logic [8:0]     EEP_CHAR  = 9'h101;
    localparam logic [7:0]     LA_FIRST  = 8'h20;
    localparam int             LA_NUM    = 224;

    // =====================================================
    // register map, byte addresses
    localparam logic [11:0]    A_CTRL    = 12'h000;
    localparam logic [11:0]    A_TMO     = 12'h004;
    localparam logic [11:0]    A_PEN     = 12'h008;
    localparam logic [11:0]    A_STAT    = 12'h00C;
    localparam logic [11:0]    A_BUSY    = 12'h010;
    localparam logic [1:0]     A_RT_PAGE = 2'h1;
    localparam int             CTRL_GAR  = 0;
    localparam int             CTRL_MC   = 1;
    localparam int             CTRL_TMO  = 2;
    localparam logic [2:0]     CTRL_RST  = 3'h0;
    localparam int             ST_STUCK  = 0;
    localparam int             ST_INV    = 1;
    localparam int             RT_VALID  = 16;
    localparam int             RT_DEL    = 17;
    localparam int             RT_MC     = 18;

    typedef enum {IN_IDLE, IN_WAIT, IN_CONN, IN_STUCK, IN_DROP} wrs_in_t;

endpackage

// *** rtl/wrs_core.sv ***
// wormhole routing switch core: routing, arbitration, time-out and registers
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
module wrs_core
    import wrs_pkg::*;
#(
    parameter int              NP      = 4,
    parameter int              TMO_W   = 16,
    parameter logic [15:0]     TMO_DEF = 16'h0400
)(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // register slave
    input  wire logic [11:0]          avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // receive side of each port
    input  wire logic [NP-1:0]        rx_valid,
    input  wire logic [NP*CH_W-1:0]   rx_char,
    output logic [NP-1:0]             rx_ready,
    // transmit side of each port
    output logic [NP-1:0]             tx_valid,
    output logic [NP*CH_W-1:0]        tx_char,
    input  wire logic [NP-1:0]        tx_ready
);

    localparam int IW = (NP > 1) ? $clog2(NP) : 1;
    localparam int EW = NP + 3;

    // =====================================================
    // helpers
    function automatic logic [NP-1:0] rr_pick(input logic [NP-1:0] req, input logic [IW-1:0] ptr);
        logic [NP-1:0] g;
        logic          found;
        int            idx;
        g     = '0;
        found = 1'b0;
        for (int k = 0; k < NP; k++)
        begin
            idx = (int'(ptr) + k) % NP;
            if (!found && req[idx])
            begin
                g[idx] = 1'b1;
                found  = 1'b1;
            end
        end
        return g;
    endfunction

    function automatic logic [NP-1:0] lowest(input logic [NP-1:0] v);
        logic [NP-1:0] g;
        g = '0;
        for (int k = NP - 1; k >= 0; k--)
        begin
            if (v[k])
                g = NP'(1) << k;
        end
        return g;
    endfunction

    // returns {ok, delete, multicast, mask}
    function automatic logic [EW-1:0] route_dec(input logic [7:0] a, input logic [EW-1:0] e,
                                                input logic [2:0] ctrl, input logic [NP-1:0] pen);
        logic [NP-1:0] m;
        logic          mc;
        m  = '0;
        mc = 1'b0;
        if (a < LA_FIRST)
        begin
            if (int'(a) < NP)
                m = NP'(1) << a;                              // RULE23
            return {(int'(a) < NP), 1'b1, 1'b0, m};            // RULE24 RULE25
        end
        if (e[NP+2] && ctrl[CTRL_MC])
        begin
            m  = e[NP-1:0] & pen;                             // RULE13 RULE16
            mc = 1'b1;
        end
        else if (ctrl[CTRL_GAR])
            m = e[NP-1:0] & pen;                              // RULE11
        else
            m = lowest(e[NP-1:0]);
        return {(e[NP] && (m != '0)), e[NP+1], mc, m};         // RULE1 RULE25
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[b*8 +: 8] = n[b*8 +: 8];
        end
        return r;
    endfunction

    // =====================================================
    // state
    logic [2:0]        ctrl_r;
    logic [TMO_W-1:0]  tmo_r;
    logic [NP-1:0]     pen_r;
    logic              stuck_err_r;
    logic              inv_err_r;
    logic [EW-1:0]     rt_r      [LA_NUM];
    logic              wait_r;
    logic [31:0]       rdata_r;

    logic [NP-1:0]     hold_v_r;
    logic [CH_W-1:0]   hold_d_r  [NP];
    logic [NP-1:0]     rdy_r;
    wrs_in_t           st_r      [NP];
    logic [NP-1:0]     req_r     [NP];
    logic [NP-1:0]     mc_r;
    logic [NP-1:0]     conn_r    [NP];
    logic [NP-1:0]     started_r;
    logic [TMO_W-1:0]  tcnt_r    [NP];

    logic [NP-1:0]     busy_r;
    logic [IW-1:0]     owner_r   [NP];
    logic [IW-1:0]     rr_r      [NP];
    logic [NP-1:0]     txv_r;
    logic [CH_W-1:0]   txd_r     [NP];

    logic [NP-1:0]     gnt       [NP];
    logic [NP-1:0]     acc       [NP];
    logic [EW-1:0]     hdr       [NP];
    logic [NP-1:0]     out_free;
    logic [NP-1:0]     fire;
    logic [NP-1:0]     eep_fire;
    logic [NP-1:0]     stuck;
    logic [NP-1:0]     consume;
    logic [NP-1:0]     out_ld;
    logic [NP-1:0]     rel;
    logic [CH_W-1:0]   out_dat   [NP];
    logic              bus_wr;
    logic [31:0]       rd_mux;

    assign out_free = ~txv_r | tx_ready;
    assign bus_wr   = avs_write && !wait_r;

    // =====================================================
    // arbitration: each free output picks one waiting input
    always_comb
    begin
        logic [NP-1:0] want;
        logic [NP-1:0] gi;
        want = '0;
        gi   = '0;
        for (int o = 0; o < NP; o++)
        begin
            for (int i = 0; i < NP; i++)
                want[i] = (st_r[i] == IN_WAIT) && req_r[i][o];
            gnt[o] = busy_r[o] ? '0 : rr_pick(want, rr_r[o]);   // RULE8 RULE9 RULE26
        end
        for (int i = 0; i < NP; i++)
        begin
            for (int o = 0; o < NP; o++)
                gi[o] = gnt[o][i];
            if (mc_r[i])
                acc[i] = (gi == req_r[i]) ? gi : '0;          // RULE14
            else
                acc[i] = lowest(gi);                          // RULE12
        end
    end

    // =====================================================
    // per-input forwarding decisions
    always_comb
    begin
        logic [7:0] la;
        la = '0;
        for (int i = 0; i < NP; i++)
        begin
            la       = hold_d_r[i][7:0];
            hdr[i]   = route_dec(la, rt_r[(la >= LA_FIRST) ? int'(la - LA_FIRST) : 0], ctrl_r, pen_r);
            fire[i]  = (st_r[i] == IN_CONN) && hold_v_r[i] && ((conn_r[i] & ~out_free) == '0);  // RULE7 RULE15
            eep_fire[i] = (st_r[i] == IN_STUCK) && ((conn_r[i] & ~out_free) == '0);
            stuck[i] = (st_r[i] == IN_CONN) && !fire[i] && started_r[i]
                       && ctrl_r[CTRL_TMO] && (tcnt_r[i] == '0);  // RULE19 RULE21
            consume[i] = fire[i] || (st_r[i] == IN_DROP && hold_v_r[i])
                       || (st_r[i] == IN_IDLE && hold_v_r[i]
                           && (hold_d_r[i][CH_CTL] || !hdr[i][EW-1] || hdr[i][EW-2]));  // RULE2 RULE3
        end
    end

    // =====================================================
    // output loading from the connected input
    always_comb
    begin
        logic [IW-1:0] s;
        s = '0;
        for (int o = 0; o < NP; o++)
        begin
            s          = owner_r[o];
            out_ld[o]  = busy_r[o] && conn_r[s][o] && (fire[s] || eep_fire[s]);
            out_dat[o] = eep_fire[s] ? EEP_CHAR : hold_d_r[s];           // RULE20
            rel[o]     = out_ld[o] && (eep_fire[s] || hold_d_r[s][CH_CTL]);
        end
    end

    // =====================================================
    // input holding stage
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NP; i++)
        begin
            if (rst)
            begin
                hold_v_r[i] <= 1'b0;
                hold_d_r[i] <= '0;
                rdy_r[i]    <= 1'b0;
            end
            else if (rx_valid[i] && rdy_r[i])
            begin
                hold_v_r[i] <= 1'b1;
                hold_d_r[i] <= rx_char[i*CH_W +: CH_W];
                rdy_r[i]    <= 1'b0;
            end
            else
            begin
                hold_v_r[i] <= hold_v_r[i] && !consume[i];
                rdy_r[i]    <= !(hold_v_r[i] && !consume[i]);
            end
        end
    end

    // =====================================================
    // input packet state machines
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NP; i++)
        begin
            if (rst)
            begin
                st_r[i]      <= IN_IDLE;
                req_r[i]     <= '0;
                mc_r[i]      <= 1'b0;
                conn_r[i]    <= '0;
                started_r[i] <= 1'b0;
                tcnt_r[i]    <= '0;
            end
            else
            begin
                unique case (st_r[i])
                    IN_IDLE:
                        if (hold_v_r[i] && !hold_d_r[i][CH_CTL])
                        begin
                            st_r[i]  <= hdr[i][EW-1] ? IN_WAIT : IN_DROP;   // RULE25
                            req_r[i] <= hdr[i][NP-1:0];                      // RULE4
                            mc_r[i]  <= hdr[i][EW-3];
                        end
                    IN_WAIT:
                        if (acc[i] != '0)
                        begin
                            st_r[i]      <= IN_CONN;                          // RULE4
                            conn_r[i]    <= acc[i];
                            started_r[i] <= 1'b0;
                            tcnt_r[i]    <= tmo_r;
                        end
                    IN_CONN:
                        if (fire[i])
                        begin
                            st_r[i]      <= hold_d_r[i][CH_CTL] ? IN_IDLE : IN_CONN;  // RULE10
                            started_r[i] <= !hold_d_r[i][CH_CTL];
                            tcnt_r[i]    <= tmo_r;                                    // RULE27
                        end
                        else if (stuck[i])
                            st_r[i] <= IN_STUCK;                                      // RULE20
                        else if (started_r[i] && tcnt_r[i] != '0)
                            tcnt_r[i] <= tcnt_r[i] - TMO_W'(1);                        // RULE18
                    IN_STUCK:
                        if (eep_fire[i])
                            st_r[i] <= (hold_v_r[i] && hold_d_r[i][CH_CTL]) ? IN_IDLE : IN_DROP;
                    IN_DROP:
                        if (hold_v_r[i] && hold_d_r[i][CH_CTL])
                            st_r[i] <= IN_IDLE;
                endcase
            end
        end
    end

    // =====================================================
    // output ownership, fairness pointer and transmit register
    always_ff @(posedge mclk)
    begin
        for (int o = 0; o < NP; o++)
        begin
            if (rst)
            begin
                busy_r[o]  <= 1'b0;
                owner_r[o] <= '0;
                rr_r[o]    <= '0;
                txv_r[o]   <= 1'b0;
                txd_r[o]   <= '0;
            end
            else
            begin
                if (rel[o])
                    busy_r[o] <= 1'b0;                                 // RULE6 RULE10
                for (int i = 0; i < NP; i++)
                begin
                    if (acc[i][o])
                    begin
                        busy_r[o]  <= 1'b1;
                        owner_r[o] <= IW'(i);
                        rr_r[o]    <= IW'((i + 1) % NP);               // RULE26
                    end
                end
                if (out_ld[o])
                begin
                    txv_r[o] <= 1'b1;                                  // RULE5
                    txd_r[o] <= out_dat[o];
                end
                else if (tx_ready[o])
                    txv_r[o] <= 1'b0;
            end
        end
    end

    // =====================================================
    // configuration registers
    always_comb
    begin
        rd_mux = '0;
        if (avs_address[11:10] == A_RT_PAGE && avs_address[9:2] >= LA_FIRST)
        begin
            rd_mux[NP-1:0] = rt_r[int'(avs_address[9:2] - LA_FIRST)][NP-1:0];
            rd_mux[RT_VALID] = rt_r[int'(avs_address[9:2] - LA_FIRST)][NP];
            rd_mux[RT_DEL]   = rt_r[int'(avs_address[9:2] - LA_FIRST)][NP+1];
            rd_mux[RT_MC]    = rt_r[int'(avs_address[9:2] - LA_FIRST)][NP+2];
        end
        else if (avs_address == A_CTRL)
            rd_mux[2:0] = ctrl_r;
        else if (avs_address == A_TMO)
            rd_mux[TMO_W-1:0] = tmo_r;
        else if (avs_address == A_PEN)
            rd_mux[NP-1:0] = pen_r;
        else if (avs_address == A_STAT)
            rd_mux[1:0] = {inv_err_r, stuck_err_r};
        else if (avs_address == A_BUSY)
            rd_mux[NP-1:0] = busy_r;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end
        else if ((avs_read || avs_write) && wait_r)
        begin
            wait_r  <= 1'b0;
            rdata_r <= rd_mux;
        end
        else
            wait_r <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        logic [31:0] w;
        w = '0;
        if (rst)
        begin
            ctrl_r <= CTRL_RST;                                       // RULE17
            tmo_r  <= TMO_W'(TMO_DEF);
            pen_r  <= '1;
            for (int e = 0; e < LA_NUM; e++)
                rt_r[e] <= '0;                                        // RULE17
        end
        else if (bus_wr)
        begin
            if (avs_address[11:10] == A_RT_PAGE && avs_address[9:2] >= LA_FIRST)
            begin
                w = be_merge(rd_mux, avs_writedata, avs_byteenable);
                rt_r[int'(avs_address[9:2] - LA_FIRST)] <= {w[RT_MC], w[RT_DEL], w[RT_VALID], w[NP-1:0]};  // RULE22
            end
            else if (avs_address == A_CTRL)
            begin
                w = be_merge(rd_mux, avs_writedata, avs_byteenable);
                ctrl_r <= w[2:0];
            end
            else if (avs_address == A_TMO)
            begin
                w = be_merge(rd_mux, avs_writedata, avs_byteenable);
                tmo_r <= w[TMO_W-1:0];                                // RULE22
            end
            else if (avs_address == A_PEN)
            begin
                w = be_merge(rd_mux, avs_writedata, avs_byteenable);
                pen_r <= w[NP-1:0];
            end
        end
    end

    // error flags: a new event wins over a write-one-to-clear
    always_ff @(posedge mclk)
    begin
        logic clr_s;
        logic clr_i;
        clr_s = bus_wr && avs_address == A_STAT && avs_byteenable[0] && avs_writedata[ST_STUCK];
        clr_i = bus_wr && avs_address == A_STAT && avs_byteenable[0] && avs_writedata[ST_INV];
        if (rst)
        begin
            stuck_err_r <= 1'b0;
            inv_err_r   <= 1'b0;
        end
        else
        begin
            stuck_err_r <= (stuck_err_r && !clr_s) || (|stuck);      // RULE20
            inv_err_r   <= (inv_err_r && !clr_i) || (|(consume & ~hold_d_r_ctl() & inv_hdr()));  // RULE25
        end
    end

    function automatic logic [NP-1:0] hold_d_r_ctl();
        logic [NP-1:0] v;
        v = '0;
        for (int i = 0; i < NP; i++)
            v[i] = hold_d_r[i][CH_CTL];
        return v;
    endfunction

    function automatic logic [NP-1:0] inv_hdr();
        logic [NP-1:0] v;
        v = '0;
        for (int i = 0; i < NP; i++)
            v[i] = (st_r[i] == IN_IDLE) && !hdr[i][EW-1];
        return v;
    endfunction

    // =====================================================
    // outputs
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign rx_ready        = rdy_r;
    assign tx_valid        = txv_r;
    for (genvar o = 0; o < NP; o++)
    begin : g_tx
        assign tx_char[o*CH_W +: CH_W] = txd_r[o];
    end

    // =====================================================
    // checks
    for (genvar o = 0; o < NP; o++)
    begin : g_chk_o
        a_tx_stall_hold: // RULE7
            assert property (@(posedge mclk) disable iff (rst)
                txv_r[o] && !tx_ready[o] |=> txv_r[o] && $stable(txd_r[o]))
            else $error("transmit character changed while stalled");
        a_owner_kept: // RULE6
            assert property (@(posedge mclk) disable iff (rst)
                busy_r[o] && !rel[o] |=> busy_r[o] && $stable(owner_r[o]))
            else $error("output reassigned mid packet");
        a_grant_free: // RULE8
            assert property (@(posedge mclk) disable iff (rst)
                st_r[o] == IN_WAIT && (req_r[o] & ~busy_r) == '0 |=> st_r[o] == IN_WAIT)
            else $error("input connected to a busy output");
        a_release_once: // RULE10
            assert property (@(posedge mclk) disable iff (rst)
                rel[o] |=> !busy_r[o] || owner_r[o] != $past(owner_r[o]) || $past(gnt[o]) == '0)
            else $error("output not released after packet");
    end

    for (genvar i = 0; i < NP; i++)
    begin : g_chk_i
        a_mc_wait_all: // RULE15
            assert property (@(posedge mclk) disable iff (rst)
                st_r[i] == IN_CONN && |(conn_r[i] & ~out_free) |-> (out_ld & conn_r[i]) == '0)
            else $error("multicast character sent to partial set");
        a_tmo_disabled: // RULE21
            assert property (@(posedge mclk) disable iff (rst)
                !ctrl_r[CTRL_TMO] && st_r[i] == IN_CONN |=> st_r[i] != IN_STUCK)
            else $error("time-out while disabled");
        a_stuck_flag: // RULE20
            assert property (@(posedge mclk) disable iff (rst)
                stuck[i] |=> stuck_err_r && st_r[i] == IN_STUCK)
            else $error("stuck packet not recorded");
        a_del_one: // RULE2
            assert property (@(posedge mclk) disable iff (rst)
                st_r[i] == IN_IDLE && hold_v_r[i] && !hold_d_r[i][CH_CTL] && hdr[i][EW-1]
                |=> st_r[i] == IN_WAIT && !consume[i])
            else $error("more than one header character removed");
        a_inv_drop: // RULE25
            assert property (@(posedge mclk) disable iff (rst)
                st_r[i] == IN_IDLE && hold_v_r[i] && !hold_d_r[i][CH_CTL] && !hdr[i][EW-1]
                |=> st_r[i] == IN_DROP && inv_err_r)
            else $error("invalid address not discarded");
        c_mc_start:
            cover property (@(posedge mclk) st_r[i] == IN_WAIT && mc_r[i] && acc[i] != '0);
        c_stuck:
            cover property (@(posedge mclk) eep_fire[i]);
        c_contend:
            cover property (@(posedge mclk) st_r[i] == IN_WAIT && acc[i] == '0 ##1 acc[i] != '0);
    end

    a_reset_clean: // RULE17
        assert property (@(posedge mclk) rst |=> ctrl_r == CTRL_RST && rt_r[0] == '0)
        else $error("reset left routing enabled");

endmodule // wrs_core

// *** verif/wrs_far_node.sv ***
// far-side node model: accepts switch output characters with optional stalls
`timescale 1ns/1ps
module wrs_far_node
    import wrs_pkg::*;
#(
    parameter int NP = 4
)(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // switch transmit side
    input  wire logic [NP-1:0]        tx_valid,
    input  wire logic [NP*CH_W-1:0]   tx_char,
    output logic [NP-1:0]             tx_ready,
    // model control and log
    input  wire logic                 slow,
    output logic [NP*CH_W-1:0]        last_r,
    output logic [NP*8-1:0]           cnt_r
);
    logic [15:0] lfsr_r;

    // =====================================================
    // credit: slow mode withholds credit on pseudo-random cycles
    always_ff @(posedge mclk)
    begin
        lfsr_r   <= rst ? 16'hace1 : {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        tx_ready <= rst ? '0 : (slow ? lfsr_r[NP-1:0] : '1);
    end

    // =====================================================
    // log what each link really accepted
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NP; i++)
        begin
            if (rst)
                cnt_r[i*8+:8] <= 8'h00;
            else if (tx_valid[i] && tx_ready[i])
            begin
                cnt_r[i*8+:8]      <= cnt_r[i*8+:8] + 8'h01;
                last_r[i*CH_W+:CH_W] <= tx_char[i*CH_W+:CH_W];
            end
        end
    end
endmodule // wrs_far_node

// *** verif/wormhole_routing_switch_core_tb_top.sv ***
// self-checking bench for the wormhole routing switch core
`timescale 1ns/1ps
module wormhole_routing_switch_core_tb_top;
    import wrs_pkg::*;
    logic        mclk = 0, rst = 1, rd = 0, wr = 0, slow = 0, wq;
    logic [11:0] adr = 0;
    logic [31:0] wd = 0, rdat, q, seed = 32'h648d, cnt;
    logic [3:0]  rv = 0, rr, tv, tr;
    logic [35:0] rc = 0, tc, last;
    int          error_cnt = 0, tests_run = 0, cyc = 0;

    wrs_core #(.NP(4)) uut (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wq),
        .rx_valid(rv), .rx_char(rc), .rx_ready(rr), .tx_valid(tv), .tx_char(tc), .tx_ready(tr));
    wrs_far_node #(.NP(4)) far (.mclk(mclk), .rst(rst), .tx_valid(tv), .tx_char(tc), .tx_ready(tr),
        .slow(slow), .last_r(last), .cnt_r(cnt));

    always #4 mclk = ~mclk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // =====================================================
    // bus, link and compare helpers
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        do @(posedge mclk); while (wq !== 1'b0);
        q = rdat;
        rd <= 0; wr <= 0;
        @(posedge mclk);
    endtask

    task automatic send(input int p, input logic [8:0] c);
        rv[p] <= 1; rc[p*9+:9] <= c;
        do @(posedge mclk); while (rr[p] !== 1'b1);
        rv[p] <= 0;
        @(posedge mclk);
    endtask

    // header, n random data bytes, normal end
    task automatic pkt(input int p, input logic [7:0] h, input int n);
        send(p, {1'b0, h});
        repeat (n) send(p, {1'b0, 8'(xs())});
        send(p, 9'h100);
    endtask

    task automatic waitn(input int p, input int n);
        for (int i = 0; i < 200 && cnt[p*8+:8] !== 8'(n); i++) @(posedge mclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    // =====================================================
    // scenarios
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        bus(0, A_CTRL, 0); chk("ctrl", 0, q);
        bus(0, A_TMO, 0); chk("timeout", 32'h0000_0400, q);
        bus(0, 12'h4a0, 0); chk("route entry", 0, q);
        bus(0, 12'hffc, 0); chk("unmapped", 0, q);
        $display("test reset done");
        slow <= 1;
        pkt(1, 8'h02, 3); waitn(2, 4); chk("path count", 4, cnt[23:16]);
        chk("path end", 9'h100, last[26:18]);
        $display("test path done");
        slow <= 0;
        bus(1, 12'h500, 32'h0003_0008); pkt(1, 8'h40, 2); waitn(3, 3); chk("delete count", 3, cnt[31:24]);
        bus(1, 12'h504, 32'h0001_0004); pkt(3, 8'h41, 2); waitn(2, 8); chk("keep count", 8, cnt[23:16]);
        $display("test logical done");
        bus(1, A_CTRL, 2); bus(1, 12'h580, 32'h0005_000c); pkt(1, 8'h60, 1);
        waitn(3, 6); chk("multicast a", 6, cnt[31:24]); chk("multicast b", 11, cnt[23:16]);
        $display("test multicast done");
        // port 2 kept busy by an open packet, so the adaptive entry must pick port 3
        bus(1, A_CTRL, 1); bus(1, 12'h584, 32'h0001_000c); send(3, 9'h002); send(3, 9'h011);
        pkt(1, 8'h61, 1); waitn(3, 9); chk("adaptive", 9, cnt[31:24]);
        send(3, 9'h100); waitn(2, 13); chk("adaptive busy", 13, cnt[23:16]);
        $display("test adaptive done");
        pkt(1, 8'h50, 2); repeat (10) @(posedge mclk);
        bus(0, A_STAT, 0); chk("invalid flag", 1, q[1]);
        bus(1, A_STAT, 3); bus(1, A_TMO, 20); bus(1, A_CTRL, 4);
        send(1, 9'h002); send(1, 9'h055); repeat (40) @(posedge mclk);
        chk("stuck end", EEP_CHAR, last[26:18]);
        bus(0, A_STAT, 0); chk("stuck flag", 1, q[0]);
        send(1, 9'h100);
        $display("test stuck done");
        give_verdict();
    end
endmodule // wormhole_routing_switch_core_tb_top
